// File: hw/dtc_regs.svh
// Register offsets, bit positions, reset values and timing counts of the dual timer/counter
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH
`define DTC_OFF_CTRL 8'h00
`define DTC_OFF_MODE 8'h04
`define DTC_OFF_T0_LOW 8'h08
`define DTC_OFF_T0_HIGH 8'h0c
`define DTC_OFF_T1_LOW 8'h10
`define DTC_OFF_T1_HIGH 8'h14
`define DTC_OFF_IRQ_EN 8'h18
`define DTC_CTRL_RST 8'h00
`define DTC_MODE_RST 8'h00
`define DTC_CNT_RST 8'h00
`define DTC_IRQ_EN_RST 8'h00
`define DTC_BIT_T1_FLAG 7
`define DTC_BIT_T1_RUN 6
`define DTC_BIT_T0_FLAG 5
`define DTC_BIT_T0_RUN 4
`define DTC_BIT_T0_IRQ_EN 0
`define DTC_BIT_T1_IRQ_EN 1
`define DTC_BIT_GLOBAL_IRQ_EN 7
`define DTC_PER_DIV 3'h6
`define DTC_PER_DIV_LAST 3'h5
`endif

// File: hw/dtc_pkg.sv
// Types shared by the dual timer/counter design
package dtc_pkg;
  typedef enum logic [3:0] {
    DTC_MODE13 = 4'b0001,
    DTC_MODE16 = 4'b0010,
    DTC_RELOAD = 4'b0100,
    DTC_SPLIT = 4'b1000
  } dtc_mode_t;
  typedef struct packed {
    logic gate;
    logic src;
    logic [1:0] mode;
  } dtc_tcfg_t;
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic ovf;
  } dtc_cnt_t;
  typedef struct packed {
    logic t1_count;
    logic t0_count;
    logic ext_irq1;
    logic ext_irq0;
  } dtc_pins_t;
endpackage : dtc_pkg

// File: hw/dtc_tick_gen.sv
// Peripheral cycle tick: one pulse every six clocks
`timescale 1ns/1ns
`include "dtc_regs.svh"
module dtc_tick_gen (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  output logic tick_out
);
  logic [2:0] div_r;
  logic [2:0] div_nxt;
  wire last = (div_r == `DTC_PER_DIV_LAST);
  assign div_nxt = last ? 3'h0 : div_r + 3'h1;
  assign tick_out = last;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule : dtc_tick_gen

// File: hw/dtc_pin_sync.sv
// Three-stage synchronisers with agreement filter for the external pins
`timescale 1ns/1ns
module dtc_pin_sync import dtc_pkg::*; (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input dtc_pkg::dtc_pins_t pins_in,
  output dtc_pkg::dtc_pins_t level_out
);
  logic [3:0] s1_r, s2_r, s3_r, lvl_r;
  logic [3:0] raw;
  assign raw = pins_in;
  assign level_out = lvl_r;
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
      // Stage one feeds stage two only; the level moves once two and three agree
      always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          lvl_r[i] <= 1'b0;
        end else begin
          s1_r[i] <= raw[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            lvl_r[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
endmodule : dtc_pin_sync

// File: hw/dtc_top.sv
// Dual timer/counter with APB register access
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ns
`include "dtc_regs.svh"
// What this block does
// - Timer 0 auto-reload: low byte counts, overflow sets flag and reloads from high byte.
// - Reload never modifies the high byte, so the same value reloads every time.
// - High byte may be written anytime; new value applies at next reload.
// - Overflow flag clears when the processor acknowledges that timer's interrupt.
// - Timer 0 split mode runs low and high bytes as two 8-bit counters.
// - Split low byte uses timer 0 gate, source, run bit and flag.
// - Split high byte counts clock/6, runs on timer 1 run bit, sets timer 1 flag.
// - Timer 1 config in mode upper nibble; run and flag in control bits 6,7.
// - Timer 1 counts when run set; with gate set also needs interrupt 1 pin high.
// - Timer 1 rollover from all ones to zero sets timer 1 overflow flag unless timer 0 is split.
// - Mode 0: 13-bit count, low 5 bits prescale by 32, upper 3 ignored.
// - Mode 1: 16-bit count, low byte overflow increments high byte.
// - Timer 1 mode 2: 8-bit low byte, overflow sets flag, reloads from high byte.
// - Timer 1 in mode 3 stops and holds its count.
// - Timer interrupt raised only when its enable and global enable are set.
// - Timer 1 overflows serve as baud clock source for the serial port.
// - Timer operation advances once per peripheral cycle, every 6 clocks.
// - Counter operation samples pin each peripheral cycle; high then low increments.
// - Timer 0 config in mode lower nibble; run and flag in control bits 4,5.
module dtc_top import dtc_pkg::*; (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input dtc_pkg::dtc_pins_t pins_in,
  input wire logic [1:0] irq_ack_in,
  output logic t0_irq_req_out,
  output logic t1_irq_req_out,
  output logic t1_baud_pulse_out
);

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0] timer_control_reg_r;
  logic [7:0] timer_mode_reg_r;
  logic [7:0] irq_enable_reg_r;
  logic [7:0] t0_low_count_r, t0_high_count_r;
  logic [7:0] t1_low_count_r, t1_high_count_r;
  logic [31:0] prdata_r, prdata_nxt;
  logic baud_r;
  logic t0_samp_r, t1_samp_r;
  logic tick;
  dtc_pins_t pin_lvl;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  dtc_tick_gen u_tick (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .tick_out(tick)
  );

  dtc_pin_sync u_sync (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .pins_in(pins_in),
    .level_out(pin_lvl)
  );

  function automatic dtc_mode_t mode_decode(input logic [1:0] m);
    dtc_mode_t r;
    case (m)
      2'b00: r = DTC_MODE13;
      2'b01: r = DTC_MODE16;
      2'b10: r = DTC_RELOAD;
      default: r = DTC_SPLIT;
    endcase
    return r;
  endfunction : mode_decode

  // One count step; the split branch is the free-running 8-bit low byte
  function automatic dtc_cnt_t count_step(input dtc_mode_t m, input logic [7:0] lo,
                                          input logic [7:0] hi, input logic inc);
    dtc_cnt_t r;
    logic [5:0] p5;
    logic [8:0] l9;
    logic [8:0] h9;
    r.low = lo;
    r.high = hi;
    r.ovf = 1'b0;
    p5 = {1'b0, lo[4:0]} + 6'h01;
    l9 = {1'b0, lo} + 9'h001;
    h9 = {1'b0, hi} + 9'h001;
    if (inc) begin
      case (m)
        DTC_MODE13: begin
          r.low = {lo[7:5], p5[4:0]};
          if (p5[5]) begin
            r.high = h9[7:0];
            r.ovf = h9[8];
          end
        end
        DTC_MODE16: begin
          r.low = l9[7:0];
          if (l9[8]) begin
            r.high = h9[7:0];
            r.ovf = h9[8];
          end
        end
        DTC_RELOAD: begin
          // High byte is only read here, so a reload value holds for every overflow
          r.low = l9[8] ? hi : l9[7:0];
          r.ovf = l9[8];
        end
        DTC_SPLIT: begin
          r.low = l9[7:0];
          r.ovf = l9[8];
        end
        default: begin
          r.ovf = 1'b0;
        end
      endcase
    end
    return r;
  endfunction : count_step

  // ------------------------------------------------------------
  // Configuration decode
  // ------------------------------------------------------------
  dtc_tcfg_t t0_cfg, t1_cfg;
  assign t0_cfg = timer_mode_reg_r[3:0];
  assign t1_cfg = timer_mode_reg_r[7:4];
  wire t0_run_bit = timer_control_reg_r[`DTC_BIT_T0_RUN];
  wire t1_run_bit = timer_control_reg_r[`DTC_BIT_T1_RUN];
  wire t0_overflow_flag = timer_control_reg_r[`DTC_BIT_T0_FLAG];
  wire t1_overflow_flag = timer_control_reg_r[`DTC_BIT_T1_FLAG];
  dtc_mode_t t0_mode, t1_mode;
  assign t0_mode = mode_decode(t0_cfg.mode);
  assign t1_mode = mode_decode(t1_cfg.mode);
  wire t0_split = (t0_mode == DTC_SPLIT);

  // ------------------------------------------------------------
  // Count inputs
  // ------------------------------------------------------------
  // Falling edge seen between two peripheral-cycle samples
  wire t0_fall = tick & t0_samp_r & ~pin_lvl.t0_count;
  wire t1_fall = tick & t1_samp_r & ~pin_lvl.t1_count;
  wire t0_src = t0_cfg.src ? t0_fall : tick;
  wire t1_src = t1_cfg.src ? t1_fall : tick;
  wire t0_open = t0_run_bit & (~t0_cfg.gate | pin_lvl.ext_irq0);
  // While timer 0 is split, timer 1 loses its run bit and is stopped only by mode 3 or by its gate with the interrupt 1 pin low
  wire t1_run_eff = t0_split ? 1'b1 : t1_run_bit;
  wire t1_open = t1_run_eff & (~t1_cfg.gate | pin_lvl.ext_irq1);
  wire t0_inc = t0_open & t0_src;
  wire t1_inc = t1_open & t1_src & (t1_mode != DTC_SPLIT);
  wire t0h_inc = t0_split & t1_run_bit & tick;

  dtc_cnt_t t0_step, t1_step;
  assign t0_step = count_step(t0_mode, t0_low_count_r, t0_high_count_r, t0_inc);
  assign t1_step = count_step(t1_mode, t1_low_count_r, t1_high_count_r, t1_inc);
  wire [8:0] t0h_sum = {1'b0, t0_high_count_r} + 9'h001;
  wire [7:0] t0h_next = t0h_inc ? t0h_sum[7:0] : (t0_split ? t0_high_count_r : t0_step.high);
  wire t0h_ovf = t0h_inc & t0h_sum[8];

  wire t0_flag_set = t0_step.ovf;
  wire t1_flag_set = t0_split ? t0h_ovf : t1_step.ovf;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_ctrl = (paddr == `DTC_OFF_CTRL);
  wire hit_mode = (paddr == `DTC_OFF_MODE);
  wire hit_t0l = (paddr == `DTC_OFF_T0_LOW);
  wire hit_t0h = (paddr == `DTC_OFF_T0_HIGH);
  wire hit_t1l = (paddr == `DTC_OFF_T1_LOW);
  wire hit_t1h = (paddr == `DTC_OFF_T1_HIGH);
  wire hit_ien = (paddr == `DTC_OFF_IRQ_EN);
  wire hit_any = hit_ctrl | hit_mode | hit_t0l | hit_t0h | hit_t1l | hit_t1h | hit_ien;
  wire [7:0] wbyte = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = acc & ~hit_any;
  assign prdata = prdata_r;

  // Read data is loaded in the setup cycle so that it stands through the zero-wait access cycle;
  // a count read this way is one clock older than the completing edge
  wire rd_setup = psel & ~penable & ~pwrite;

  always_comb begin
    prdata_nxt = prdata_r;
    if (rd_setup) begin
      case (1'b1)
        hit_ctrl: prdata_nxt = {24'h000000, timer_control_reg_r};
        hit_mode: prdata_nxt = {24'h000000, timer_mode_reg_r};
        hit_t0l: prdata_nxt = {24'h000000, t0_low_count_r};
        hit_t0h: prdata_nxt = {24'h000000, t0_high_count_r};
        hit_t1l: prdata_nxt = {24'h000000, t1_low_count_r};
        hit_t1h: prdata_nxt = {24'h000000, t1_high_count_r};
        hit_ien: prdata_nxt = {24'h000000, irq_enable_reg_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Control register with flag set/clear
  // ------------------------------------------------------------
  logic [7:0] ctrl_base, ctrl_nxt;
  assign ctrl_base = (wr & hit_ctrl) ? wbyte : timer_control_reg_r;
  always_comb begin
    ctrl_nxt = ctrl_base;
    // A new overflow beats an acknowledge or a software clear in the same cycle
    ctrl_nxt[`DTC_BIT_T0_FLAG] = t0_flag_set | (ctrl_base[`DTC_BIT_T0_FLAG] & ~irq_ack_in[0]);
    ctrl_nxt[`DTC_BIT_T1_FLAG] = t1_flag_set | (ctrl_base[`DTC_BIT_T1_FLAG] & ~irq_ack_in[1]);
  end

  // ------------------------------------------------------------
  // Count registers; a software write overrides the count step
  // ------------------------------------------------------------
  wire [7:0] t0l_nxt = (wr & hit_t0l) ? wbyte : t0_step.low;
  wire [7:0] t0h_nxt = (wr & hit_t0h) ? wbyte : t0h_next;
  wire [7:0] t1l_nxt = (wr & hit_t1l) ? wbyte : t1_step.low;
  wire [7:0] t1h_nxt = (wr & hit_t1h) ? wbyte : t1_step.high;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      timer_control_reg_r <= `DTC_CTRL_RST;
    end else begin
      timer_control_reg_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      timer_mode_reg_r <= `DTC_MODE_RST;
    end else if (wr & hit_mode) begin
      timer_mode_reg_r <= wbyte;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      irq_enable_reg_r <= `DTC_IRQ_EN_RST;
    end else if (wr & hit_ien) begin
      irq_enable_reg_r <= wbyte;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      t0_low_count_r <= `DTC_CNT_RST;
      t0_high_count_r <= `DTC_CNT_RST;
    end else begin
      t0_low_count_r <= t0l_nxt;
      t0_high_count_r <= t0h_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      t1_low_count_r <= `DTC_CNT_RST;
      t1_high_count_r <= `DTC_CNT_RST;
    end else begin
      t1_low_count_r <= t1l_nxt;
      t1_high_count_r <= t1h_nxt;
    end
  end

  // Read data and the baud pulse, both straight from flip-flops
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      prdata_r <= 32'h00000000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      baud_r <= 1'b0;
    end else begin
      baud_r <= t1_step.ovf;
    end
  end

  // Pin samples taken once per peripheral cycle
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      t0_samp_r <= 1'b0;
      t1_samp_r <= 1'b0;
    end else if (tick) begin
      t0_samp_r <= pin_lvl.t0_count;
      t1_samp_r <= pin_lvl.t1_count;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  wire global_irq_enable = irq_enable_reg_r[`DTC_BIT_GLOBAL_IRQ_EN];
  assign t0_irq_req_out = t0_overflow_flag & irq_enable_reg_r[`DTC_BIT_T0_IRQ_EN] & global_irq_enable;
  assign t1_irq_req_out = t1_overflow_flag & irq_enable_reg_r[`DTC_BIT_T1_IRQ_EN] & global_irq_enable;
  assign t1_baud_pulse_out = baud_r;

endmodule : dtc_top

// File: tb/dtc_assertions.sv
// Port-level checks of the dual timer/counter
`timescale 1ns/1ns
module dtc_assertions (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [1:0] irq_ack_in,
  input wire logic t0_irq_req_out,
  input wire logic t1_irq_req_out,
  input wire logic t1_baud_pulse_out
);
  // ----------------------------------------
  // Shadow of software-owned bits
  // ----------------------------------------
  // Written bytes are mirrored whole, but only run, mode and enable bits are relied on; flags are hardware-set and cannot be shadowed
  logic [7:0] ctl_r, mode_r, en_r;
  wire wr_acc = psel && penable && pwrite;
  wire ctl_wr = wr_acc && paddr == 8'h00;
  wire idle1 = !ctl_r[6] && mode_r[1:0] != 2'b11;
  wire hold1 = mode_r[5:4] == 2'b11;
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) {ctl_r, mode_r, en_r} <= 24'h0;
    else if (ctl_wr) ctl_r <= pwdata[7:0];
    else if (wr_acc && paddr == 8'h04) mode_r <= pwdata[7:0];
    else if (wr_acc && paddr == 8'h18) en_r <= pwdata[7:0];
  end
  default clocking dc @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  chk_baud_single: assert property (t1_baud_pulse_out |=> !t1_baud_pulse_out)
    else $error("baud pulse longer than one cycle");
  chk_tick_gap: assert property (t1_baud_pulse_out |=> !t1_baud_pulse_out [*5])
    else $error("overflows closer than six clocks");
  chk_t0_irq_gate: assert property (t0_irq_req_out |-> en_r[0] && en_r[7])
    else $error("timer 0 request without enables");
  chk_t1_irq_gate: assert property (t1_irq_req_out |-> en_r[1] && en_r[7])
    else $error("timer 1 request without enables");
  chk_t0_ack_clear: assert property (irq_ack_in[0] && !ctl_r[4] && !ctl_wr |=> !t0_irq_req_out)
    else $error("timer 0 flag not cleared by ack");
  chk_t1_ack_clear: assert property (irq_ack_in[1] && !ctl_r[6] && !ctl_wr |=> !t1_irq_req_out)
    else $error("timer 1 flag not cleared by ack");
  chk_t1_stopped: assert property (idle1 && $past(idle1) && $past(idle1, 2) |-> !t1_baud_pulse_out)
    else $error("timer 1 overflow while not running");
  chk_t1_hold: assert property (hold1 && $past(hold1) && $past(hold1, 2) |-> !t1_baud_pulse_out)
    else $error("timer 1 overflow in hold mode");
endmodule : dtc_assertions

bind dtc_top dtc_assertions chk_u (.clock_in, .sys_rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
  .irq_ack_in, .t0_irq_req_out, .t1_irq_req_out, .t1_baud_pulse_out);

// File: tb/dtc_pin_model.sv
// Behavioural model of the external count and gate pins
`timescale 1ns/1ns
module dtc_pin_model import dtc_pkg::*; (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  input wire logic [1:0] gate_in,
  output dtc_pkg::dtc_pins_t pins_out,
  output logic [7:0] falls_out
);
  // ----------------------------------------
  // Count waveform
  // ----------------------------------------
  // Each level stands 18 clocks so the synchroniser and a six-clock sample both see it
  logic [4:0] ph_r;
  logic lvl_r;
  assign pins_out = {lvl_r, lvl_r, gate_in};
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      ph_r <= 5'h00;
      lvl_r <= 1'b0;
      falls_out <= 8'h00;
    end else if (!run_in) begin
      ph_r <= 5'h00;
    end else begin
      ph_r <= ph_r == 5'h11 ? 5'h00 : ph_r + 5'h01;
      if (ph_r == 5'h11) lvl_r <= !lvl_r;
      if (ph_r == 5'h11) falls_out <= falls_out + {7'h00, lvl_r};
    end
  end
endmodule : dtc_pin_model

// File: tb/dtc_top_test.sv
// Self-checking bench of the dual timer/counter
`timescale 1ns/1ns
`include "dtc_regs.svh"
module dtc_top_test;
  import dtc_pkg::*;
  localparam logic [7:0] CT = `DTC_OFF_CTRL, MD = `DTC_OFF_MODE, L0 = `DTC_OFF_T0_LOW, H0 = `DTC_OFF_T0_HIGH;
  localparam logic [7:0] L1 = `DTC_OFF_T1_LOW, H1 = `DTC_OFF_T1_HIGH, EN = `DTC_OFF_IRQ_EN;
  logic clock_in = 1'b0, sys_rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, prun = 1'b0, e;
  logic [7:0] paddr = 8'h00, v, w;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] irq_ack_in = 2'b00, gate = 2'b00;
  logic [31:0] prdata;
  logic pready, pslverr, t0_irq_req_out, t1_irq_req_out, t1_baud_pulse_out;
  dtc_pins_t pins;
  logic [7:0] falls;
  int n_errors = 0, comparisons = 0, cyc = 0, ta;
  always #5 clock_in = ~clock_in;
  dtc_top dut_u (.clock_in, .sys_rst_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pins_in(pins), .irq_ack_in, .t0_irq_req_out, .t1_irq_req_out, .t1_baud_pulse_out);
  dtc_pin_model pm_u (.clock_in, .sys_rst_in, .run_in(prun), .gate_in(gate), .pins_out(pins),
    .falls_out(falls));
  // ----------------------------------------
  // Bus, compare and wait helpers
  // ----------------------------------------
  task chk(input logic [7:0] g, input logic [7:0] x);
    comparisons++;
    if (g !== x) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task chkb(input logic g, input logic x);
    chk({7'h0, g}, {7'h0, x});
  endtask : chkb
  task wr(input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1; pwrite <= 1'b1; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock_in);
  endtask : wr
  // Read data and error are taken at the completing edge, then the request is released
  task rd(input logic [7:0] a, output logic [7:0] d);
    psel <= 1'b1; pwrite <= 1'b0; paddr <= a;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    e = pslverr;
    d = prdata[7:0];
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock_in);
  endtask : rd
  task ack(input logic [1:0] b);
    irq_ack_in <= b;
    @(posedge clock_in);
    irq_ack_in <= 2'b00;
    @(posedge clock_in);
  endtask : ack
  function automatic logic sig(input int s);
    return s == 2 ? t1_baud_pulse_out : s == 1 ? t1_irq_req_out : t0_irq_req_out;
  endfunction : sig
  task automatic wsig(input int s, input int lim);
    int k = 0;
    while (sig(s) !== 1'b1 && k < lim) begin
      @(posedge clock_in);
      k++;
    end
    chkb(sig(s), 1'b1);
  endtask : wsig
  task finish_test;
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    for (int i = 0; i < 7; i++) begin
      rd(8'(i * 4), v);
      chk(v, 8'h00);
    end
    rd(8'h1c, v);
    chkb(e, 1'b1);
  endtask : t_reset
  task t_reload;
    wr(MD, 8'h02); wr(H0, 8'hfd); wr(L0, 8'hfd); wr(EN, 8'h81); wr(CT, 8'h10);
    wsig(0, 40);
    rd(L0, v); chk(v, 8'hfd);
    wr(H0, 8'h80);
    ack(2'b01); chkb(t0_irq_req_out, 1'b0);
    wsig(0, 40);
    ta = cyc;
    rd(L0, v); chk(v, 8'h80);
    ack(2'b01);
    wsig(0, 800); chkb(cyc - ta == 768, 1'b1);
    rd(H0, v); chk(v, 8'h80);
    // Stop but keep the flag set, so the enable checks below see a pending overflow
    wr(CT, 8'h20);
    wr(EN, 8'h01); chkb(t0_irq_req_out, 1'b0);
    wr(EN, 8'h81); chkb(t0_irq_req_out, 1'b1);
    ack(2'b01); chkb(t0_irq_req_out, 1'b0);
  endtask : t_reload
  task t_split;
    wr(MD, 8'h03); wr(H0, 8'hfe); wr(L0, 8'h00); wr(EN, 8'h83); wr(CT, 8'h40);
    wsig(1, 20);
    chkb(t0_irq_req_out, 1'b0);
    rd(L0, v); chk(v, 8'h00);
    wr(MD, 8'h33);
    rd(L1, v);
    repeat (30) @(posedge clock_in);
    rd(L1, w); chk(w, v);
    wr(CT, 8'h80);
    chkb(t1_irq_req_out, 1'b1);
    ack(2'b10); chkb(t1_irq_req_out, 1'b0);
  endtask : t_split
  task t_gate;
    wr(MD, 8'h90); wr(L1, 8'hfe); wr(H1, 8'hff); wr(EN, 8'h00); wr(CT, 8'h40);
    repeat (40) @(posedge clock_in);
    rd(L1, v); chk(v, 8'hfe);
    gate <= 2'b10;
    wsig(2, 60);
    chkb(t1_irq_req_out, 1'b0);
    rd(CT, v); chkb(v[7], 1'b1);
    wr(CT, 8'h00);
    rd(H1, v); chk(v, 8'h00);
    gate <= 2'b00;
  endtask : t_gate
  task t_mode0;
    wr(MD, 8'h00); wr(L1, 8'hfe); wr(H1, 8'h05); wr(CT, 8'h40);
    repeat (24) @(posedge clock_in);
    wr(CT, 8'h00);
    rd(H1, v); chk(v, 8'h06);
    rd(L1, v); chk(v & 8'he0, 8'he0);
  endtask : t_mode0
  // Timer 1 auto-reload as a baud source: four ticks from fc to each overflow
  task t_baud;
    wr(MD, 8'h20); wr(H1, 8'hfc); wr(L1, 8'hfc); wr(CT, 8'h40);
    wsig(2, 40);
    ta = cyc;
    @(posedge clock_in);
    wsig(2, 40);
    chkb(cyc - ta == 24, 1'b1);
    rd(H1, v); chk(v, 8'hfc);
    rd(CT, v); chkb(v[7], 1'b1);
    wr(CT, 8'h00);
  endtask : t_baud
  task t_count;
    wr(MD, 8'h05); wr(L0, 8'h00); wr(CT, 8'h10);
    prun <= 1'b1;
    for (int k = 0; k < 400 && falls !== 8'h05; k++) @(posedge clock_in);
    prun <= 1'b0;
    repeat (20) @(posedge clock_in);
    rd(L0, v); chk(v, 8'h05);
  endtask : t_count
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      $display("[ERR] %0t timeout", $time);
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(posedge clock_in);
    t_reset();
    t_reload();
    t_split();
    t_gate();
    t_mode0();
    t_baud();
    t_count();
    finish_test();
  end
endmodule : dtc_top_test
